// ===== dv/hcf_channel_sva.sv
// Purpose: port-level checks of the hdlc channel
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only the top-level ports
`timescale 1ns/1ps
module hcf_channel_sva (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // watched ports
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       dma_mode,
  input wire logic [2:0] mode_select,
  input wire logic       rx_dma_request,
  input wire logic       tx_dma_request,
  input wire logic       data_oe_n,
  input wire logic       rx_message_end_irq,
  input wire logic       rx_pool_full_irq,
  input wire logic       tx_pool_ready_irq,
  input wire logic       rx_auto_match,
  input wire logic       tx_byte_valid,
  input wire logic       tx_byte_ready,
  input wire logic [7:0] tx_byte_data,
  input wire logic       tx_byte_last
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] rd_quiet_q;
  logic [3:0] wr_quiet_q;
  // ****************************************
  // cycles since a strobe was low, saturating
  // ****************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rd_quiet_q <= 4'hF;
    else rd_quiet_q <= !rd_n ? 4'h0 : (rd_quiet_q == 4'hF ? 4'hF : rd_quiet_q + 4'h1);
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) wr_quiet_q <= 4'hF;
    else wr_quiet_q <= !wr_n ? 4'h0 : (wr_quiet_q == 4'hF ? 4'hF : wr_quiet_q + 4'h1);
  end
  a_reset_idle: assert property ($rose(rstn) |->
    !rx_dma_request && !tx_dma_request && data_oe_n && !tx_byte_valid)
    else $error("outputs not idle after reset");
  // a drop without a recent strobe means the block count slipped
  a_rx_req_drop: assert property ($fell(rx_dma_request) |-> rd_quiet_q < 4'h8)
    else $error("rx request fell without a read");
  a_tx_req_drop: assert property ($fell(tx_dma_request) |-> wr_quiet_q < 4'h8)
    else $error("tx request fell without a write");
  a_rx_req_mode: assert property ($rose(rx_dma_request) |-> $past(dma_mode))
    else $error("rx request outside dma mode");
  a_tx_req_mode: assert property ($rose(tx_dma_request) |-> $past(dma_mode))
    else $error("tx request outside dma mode");
  a_pool_full_int: assert property (rx_pool_full_irq |-> !$past(dma_mode))
    else $error("pool full pulse in dma mode");
  a_pool_ready_int: assert property (tx_pool_ready_irq |-> !$past(dma_mode))
    else $error("pool ready pulse in dma mode");
  a_end_pulse: assert property (rx_message_end_irq |=> !rx_message_end_irq)
    else $error("message end longer than one cycle");
  a_auto_only: assert property (rx_auto_match |->
    $past(mode_select) == hcf_pkg::hcf_mode_auto) else $error("auto match outside auto mode");
  a_tx_hold: assert property (tx_byte_valid && !tx_byte_ready |=>
    tx_byte_valid && $stable(tx_byte_data) && $stable(tx_byte_last))
    else $error("tx byte changed while stalled");
  a_oe_read: assert property (!data_oe_n |-> rd_quiet_q < 4'h6)
    else $error("bus driven without a read");
endmodule
bind hcf_channel hcf_channel_sva u_sva (.*);

// ===== dv/hcf_channel_tb_top.sv
// Purpose: self-checking bench for the hdlc channel
// Assumes: dma model reads the rx buffer, bench writes the tx buffer
// Notes:   queued notes, a watcher compares
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module hcf_channel_tb_top;
  logic        ref_clk, rstn, channel_select_n, wr_n, addr_two_byte, dma_mode;
  logic        continuous_frame_tx, rx_message_complete_cmd, tx_transmit_cmd, tx_frame_end_cmd;
  logic        tx_dma_start_cmd, rx_byte_valid, rx_end_valid, rx_crc_ok, rx_aborted;
  logic        tx_byte_ready, slow, rd_n, dma_acknowledge_n, got_valid, data_oe_n;
  logic        rx_dma_request, tx_dma_request, rx_pool_full_irq, rx_message_end_irq;
  logic        tx_pool_ready_irq, rx_auto_match, tx_byte_valid, tx_byte_last;
  logic [2:0]  mode_select;
  logic [3:0]  tx_byte_count_high, rx_byte_count_high;
  logic [7:0]  data_in, data_out, tx_byte_count_low, rx_byte_count_low, rx_byte_data;
  logic [7:0]  addr_high_compare_1, addr_high_compare_2, addr_low_compare_1, addr_low_compare_2;
  logic [7:0]  tx_byte_data, got_byte, b, exp_b;
  logic [8:0]  exp_t;
  logic [11:0] exp_cnt;
  logic [7:0]  rxq[$];
  logic [8:0]  txq[$];
  int          err_count, comparisons, rd_cnt, irq_cnt;
  hcf_channel dut (.*);
  hcf_dma_model u_dma (.*);
  always #5 ref_clk = ~ref_clk;
  // sink stalls at random so the buffer must hold its words
  always @(posedge ref_clk) begin
    #1;
    tx_byte_ready = ($urandom % 4) != 0;
  end
  // ****************************************
  // watcher: oldest note against each result
  // ****************************************
  always @(posedge ref_clk) begin
    if (got_valid) begin
      rd_cnt++;
      if (rxq.size() > 0) begin
        exp_b = rxq.pop_front();
        `CHK(got_byte, exp_b)
      end
    end
    if (tx_byte_valid === 1'b1 && tx_byte_ready) begin
      exp_t = txq.size() > 0 ? txq.pop_front() : 9'h1FF;
      `CHK({tx_byte_last, tx_byte_data}, exp_t)
    end
    if (rx_message_end_irq === 1'b1) begin
      irq_cnt++;
      `CHK({rx_byte_count_high, rx_byte_count_low}, exp_cnt)
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_q(input int lim);
    for (int i = 0; i < lim && rxq.size() + txq.size() > 0; i++) tick(1);
    if (rxq.size() + txq.size() > 0) begin
      err_count++;
      $display("mismatch at %0t: wait ran out", $time);
      final_report();
    end
  endtask
  // address bytes lead, status byte follows the payload
  task automatic frame(input logic [7:0] hi, input logic [7:0] lo, input int n, input bit keep);
    rx_byte_valid = 1'b1;
    rx_byte_data = hi;
    tick(1);
    rx_byte_data = lo;
    tick(1);
    for (int i = 0; i < n; i++) begin
      rx_byte_data = 8'($urandom);
      if (keep) rxq.push_back(rx_byte_data);
      tick(1);
    end
    rx_byte_valid = 1'b0;
    {rx_end_valid, rx_crc_ok} = 2'h3;
    tick(1);
    rx_end_valid = 1'b0;
    if (keep) rxq.push_back(8'h10);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {ref_clk, rstn, rx_message_complete_cmd, tx_transmit_cmd, tx_frame_end_cmd} = 5'h00;
    {tx_dma_start_cmd, rx_byte_valid, rx_end_valid, rx_crc_ok, rx_aborted, dma_mode} = 6'h00;
    {slow, continuous_frame_tx, channel_select_n, wr_n, addr_two_byte, tx_byte_ready} = 6'h0F;
    {tx_byte_count_high, tx_byte_count_low, data_in, rx_byte_data} = 28'h0;
    {addr_high_compare_1, addr_high_compare_2} = 16'h3142;
    {addr_low_compare_1, addr_low_compare_2} = 16'h1324;
    mode_select = hcf_pkg::hcf_mode_nonauto;
    void'($urandom(14));
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK({rx_dma_request, tx_dma_request, data_oe_n, tx_byte_valid}, 4'h2)
    rstn = 1'b1;
    tick(4);
    `CHK({rx_dma_request, data_oe_n, rx_byte_count_high, rx_byte_count_low}, 14'h1000)
    channel_select_n = 1'b0;
    for (int i = 0; i < 5; i++) begin
      b = 8'($urandom);
      txq.push_back({i == 4, b});
      data_in = b;
      wr_n = 1'b0;
      tick(5);
      wr_n = 1'b1;
      tick(5);
      data_in = ~b;
    end
    channel_select_n = 1'b1;
    tx_frame_end_cmd = 1'b1;
    tick(1);
    tx_frame_end_cmd = 1'b0;
    wait_q(500);
    $display("test tx stream done");
    dma_mode = 1'b1;
    exp_cnt = 12'h006;
    frame(8'h55, addr_low_compare_2, 5, 1'b0);
    frame(8'hFC, addr_low_compare_2, 5, 1'b1);
    wait_q(3000);
    tick(80);
    `CHK(rd_cnt, 8)
    `CHK(irq_cnt, 1)
    $display("test rx small block done");
    slow = 1'b1;
    exp_cnt = 12'h020;
    frame(addr_high_compare_1, addr_low_compare_1, 31, 1'b1);
    wait_q(6000);
    tick(80);
    `CHK(rd_cnt, 40)
    `CHK(irq_cnt, 2)
    $display("test rx full block done");
    final_report();
  end
endmodule

// ===== dv/hcf_dma_model.sv
// Purpose: demand-mode dma controller reading the rx buffer
// Assumes: request is a level; acknowledge held low through a burst
// Notes:   slow stretches each strobe level from 4 to 6 cycles
`timescale 1ns/1ps
module hcf_dma_model (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rstn,
  // device side
  input wire logic       rx_dma_request,
  input wire logic [7:0] data_out,
  output logic           rd_n,
  output logic           dma_acknowledge_n,
  // bench side
  input wire logic       slow,
  output logic           got_valid,
  output logic [7:0]     got_byte
);
  initial begin
    {rd_n, dma_acknowledge_n, got_valid, got_byte} = 11'h600;
    forever begin
      @(posedge ref_clk);
      #1;
      // cycles while the level stays up
      if (rstn && rx_dma_request) begin
        dma_acknowledge_n = 1'b0;
        rd_n = 1'b0;
        repeat (slow ? 5 : 3) @(posedge ref_clk);
        #1;
        got_byte = data_out;
        @(posedge ref_clk);
        #1;
        rd_n = 1'b1;
        got_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        got_valid = 1'b0;
        repeat (slow ? 4 : 2) @(posedge ref_clk);
      end else begin
        dma_acknowledge_n = 1'b1;
      end
    end
  end
endmodule

// ===== logic/hcf_channel.sv
// Purpose: one hdlc channel: rx/tx fifos, dma requests, address screening
// Assumes: line engine delivers destuffed bytes and crc verdict
// Notes:   bus pins are asynchronous and pass two flip-flops
// Contract
// RULE_01: 32-byte rx block: drop request at read n-1
// RULE_02: small rx blocks: drop at falling last read
// RULE_03: fast controller: no extra request per block
// RULE_04: controller keeps cycling while request active
// RULE_05: pulsed acknowledge: reassert, drop on next fall
// RULE_06: two 64-byte fifos, one 32-byte half reachable
// RULE_07: 32 bytes stored: request rx readout
// RULE_08: keep rx block until confirmed
// RULE_09: confirmation shifts next block, message end
// RULE_10: long frames: repeated 32-byte block requests
// RULE_11: rx fifo holds up to 17 frames
// RULE_12: append status byte after each frame
// RULE_13: rx dma blocks 4, 8, 16, 32; byte count
// RULE_14: tx pool ready when half free again
// RULE_15: continuous bit gates loading of next frame
// RULE_16: dma tx: 32-byte blocks plus remainder
// RULE_17: hdlc framing and crc from line engine
// RULE_18: six operating modes select processing level
// RULE_19: address screening in auto, nonauto, transparent 1
// RULE_20: group values accepted as high bytes
// RULE_21: auto: low1 protocol, low2 stored
// RULE_22: nonauto two-byte: either low stores frame
// RULE_23: unmatched address discards whole frame
// RULE_24: transparent 1 high only; nonauto one-byte lows
// RULE_25: tx request drops at write n-1, reasserts
// RULE_26: controller uses level demand transfer mode
// RULE_27: reset empties fifos, drops requests, frame count
`timescale 1ns/1ps
`include "hcf_params.svh"
module hcf_channel (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // parallel bus pins
  input  wire logic        channel_select_n,
  input  wire logic        dma_acknowledge_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  output logic             rx_dma_request,
  output logic             tx_dma_request,
  // configuration and commands
  input  wire logic [2:0]  mode_select,
  input  wire logic        addr_two_byte,
  input  wire logic        dma_mode,
  input  wire logic        continuous_frame_tx,
  input  wire logic [7:0]  addr_high_compare_1,
  input  wire logic [7:0]  addr_high_compare_2,
  input  wire logic [7:0]  addr_low_compare_1,
  input  wire logic [7:0]  addr_low_compare_2,
  input  wire logic        rx_message_complete_cmd,
  input  wire logic        tx_transmit_cmd,
  input  wire logic        tx_frame_end_cmd,
  input  wire logic        tx_dma_start_cmd,
  input  wire logic [3:0]  tx_byte_count_high,
  input  wire logic [7:0]  tx_byte_count_low,
  // status
  output logic             rx_pool_full_irq,
  output logic             rx_message_end_irq,
  output logic             tx_pool_ready_irq,
  output logic             rx_auto_match,
  output logic [3:0]       rx_byte_count_high,
  output logic [7:0]       rx_byte_count_low,
  // line engine receive side
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte_data,
  input  wire logic        rx_end_valid,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_aborted,
  // line engine transmit side
  output logic             tx_byte_valid,
  output logic [7:0]       tx_byte_data,
  output logic             tx_byte_last,
  input  wire logic        tx_byte_ready
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [5:0] hcf_round_blk(input logic [5:0] len);
    if (len <= `HCF_BLK_4) return `HCF_BLK_4;
    else if (len <= `HCF_BLK_8) return `HCF_BLK_8;
    else if (len <= `HCF_BLK_16) return `HCF_BLK_16;
    else return `HCF_BLK_32;
  endfunction

  // {store, auto protocol} for a low address byte
  function automatic logic [1:0] hcf_low_result(input hcf_pkg::hcf_mode_t m,
                                                input logic [7:0] b);
    if (m == hcf_pkg::hcf_mode_auto && b == addr_low_compare_1) return 2'h1;
    if (b == addr_low_compare_1 || b == addr_low_compare_2) return 2'h2;
    return 2'h0;
  endfunction

  // ************************************************************
  // pin synchronisers and edges
  // ************************************************************
  logic [11:0] sy1_q, sy2_q, sy3_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sy1_q <= 12'hFFF;
      sy2_q <= 12'hFFF;
      sy3_q <= 12'hFFF;
    end else begin
      sy1_q <= {data_in, wr_n, rd_n, dma_acknowledge_n, channel_select_n};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end
  logic [7:0] pin_data;
  logic       acc2, acc3, ack_rise, ack_fall, rd_rise, rd_fall, wr_rise;
  assign pin_data = sy2_q[11:4];
  assign acc2     = !sy2_q[0] || !sy2_q[1];
  assign acc3     = !sy3_q[0] || !sy3_q[1];
  assign ack_rise = (!sy3_q[1] && sy2_q[1]) || (!sy3_q[0] && sy2_q[0]);
  assign ack_fall = (sy3_q[1] && !sy2_q[1]) || (sy3_q[0] && !sy2_q[0]);
  assign rd_rise  = acc3 && !sy3_q[2] && sy2_q[2];
  assign rd_fall  = acc2 && sy3_q[2] && !sy2_q[2];
  assign wr_rise  = acc3 && !sy3_q[3] && sy2_q[3];

  // ************************************************************
  // receive fifo and address screening
  // ************************************************************
  logic [7:0]  rx_mem [0:63];                         // RULE_06
  logic [63:0] rx_end_q;
  logic [5:0]  rx_wr_q, rx_base_q, rx_cnt_q;
  logic [6:0]  rx_count_q;
  logic [4:0]  rx_frames_q;
  logic [11:0] rx_flen_q;
  logic        rx_ann_q, rx_pause_q, rx_done_q;
  hcf_pkg::hcf_addr_st_t ast_q;
  hcf_pkg::hcf_mode_t    mode;
  assign mode = hcf_pkg::hcf_mode_t'(mode_select);     // RULE_18

  logic       hi_ok, recog, room, push_b, push_s, confirm;
  logic [1:0] low_r;
  assign hi_ok = rx_byte_data == addr_high_compare_1 ||
                 rx_byte_data == addr_high_compare_2 ||
                 rx_byte_data == `HCF_GROUP_ADDR_A ||
                 rx_byte_data == `HCF_GROUP_ADDR_B;    // RULE_20
  assign recog = mode == hcf_pkg::hcf_mode_auto || mode == hcf_pkg::hcf_mode_nonauto ||
                 mode == hcf_pkg::hcf_mode_transp1;    // RULE_19
  assign low_r = hcf_low_result(mode, rx_byte_data);
  // full fifo or frame limit drops bytes rather than corrupting stored frames
  assign room   = rx_count_q < `HCF_FIFO_DEPTH && rx_frames_q < `HCF_MAX_FRAMES; // RULE_11
  assign push_b = rx_byte_valid && room && (ast_q == hcf_pkg::hcf_a_data ||
                  (ast_q == hcf_pkg::hcf_a_high && !recog));
  assign push_s = rx_end_valid && room && ast_q == hcf_pkg::hcf_a_data;  // RULE_23

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ast_q         <= hcf_pkg::hcf_a_high;
      rx_auto_match <= 1'b0;
    end else begin
      rx_auto_match <= 1'b0;
      if (rx_end_valid) begin
        ast_q <= hcf_pkg::hcf_a_high;
      end else if (rx_byte_valid) begin
        unique case (ast_q)
          hcf_pkg::hcf_a_high: begin
            if (!recog) ast_q <= hcf_pkg::hcf_a_data;
            else if (mode == hcf_pkg::hcf_mode_transp1)
              ast_q <= hi_ok ? hcf_pkg::hcf_a_data : hcf_pkg::hcf_a_skip; // RULE_24
            else if (addr_two_byte)
              ast_q <= hi_ok ? hcf_pkg::hcf_a_low : hcf_pkg::hcf_a_skip;
            else begin
              ast_q         <= low_r[1] ? hcf_pkg::hcf_a_data : hcf_pkg::hcf_a_skip; // RULE_24
              rx_auto_match <= low_r[0];                                          // RULE_21
            end
          end
          hcf_pkg::hcf_a_low: begin
            ast_q         <= low_r[1] ? hcf_pkg::hcf_a_data : hcf_pkg::hcf_a_skip; // RULE_22
            rx_auto_match <= low_r[0];                                          // RULE_21
          end
          hcf_pkg::hcf_a_data: ast_q <= hcf_pkg::hcf_a_data;
          hcf_pkg::hcf_a_skip: ast_q <= hcf_pkg::hcf_a_skip;
        endcase
      end
    end
  end

  // status byte carries the line engine's crc and abort verdict
  always_ff @(posedge ref_clk) begin
    if (push_b) rx_mem[rx_wr_q] <= rx_byte_data;
    else if (push_s) rx_mem[rx_wr_q] <= {2'h0, rx_aborted, rx_crc_ok, 4'h0}; // RULE_12 RULE_17
  end

  // first frame end within the accessible half decides the block
  logic       blk_end;
  logic [5:0] blk_len, dma_size;
  logic       blk_ready;
  always_comb begin
    blk_end = 1'b0;
    blk_len = `HCF_BLK_32;
    for (int i = 0; i < 32; i++) begin
      if (!blk_end && 7'(i) < rx_count_q && rx_end_q[rx_base_q + 6'(i)]) begin
        blk_end = 1'b1;
        blk_len = 6'(i + 1);
      end
    end
  end
  assign blk_ready = blk_end || rx_count_q >= `HCF_HALF_SIZE;      // RULE_07 RULE_10
  assign dma_size  = blk_end ? hcf_round_blk(blk_len) : `HCF_BLK_32; // RULE_13
  assign confirm   = blk_ready && (dma_mode ? rd_rise && rx_cnt_q == dma_size - 6'h01
                                            : rx_message_complete_cmd); // RULE_08

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_wr_q     <= 6'h00;
      rx_base_q   <= 6'h00;
      rx_count_q  <= 7'h00;
      rx_frames_q <= 5'h00;
      rx_end_q    <= 64'h0;                                        // RULE_27
    end else begin
      if (push_b || push_s) begin
        rx_wr_q           <= rx_wr_q + 6'h01;
        rx_end_q[rx_wr_q] <= push_s;
      end
      if (confirm) rx_base_q <= rx_base_q + blk_len;               // RULE_09
      rx_count_q  <= rx_count_q + 7'(push_b || push_s) - (confirm ? 7'(blk_len) : 7'h00);
      rx_frames_q <= rx_frames_q + 5'(push_s) - 5'(confirm && blk_end);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_flen_q          <= 12'h000;
      rx_byte_count_high <= 4'h0;
      rx_byte_count_low  <= 8'h00;
    end else if (push_s) begin
      rx_flen_q                                 <= 12'h000;
      {rx_byte_count_high, rx_byte_count_low}   <= rx_flen_q + 12'h001; // RULE_13
    end else if (rx_end_valid) begin
      rx_flen_q <= 12'h000;
    end else if (push_b) begin
      rx_flen_q <= rx_flen_q + 12'h001;
    end
  end

  // announce each block once; cleared when it is confirmed
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_ann_q           <= 1'b0;
      rx_pool_full_irq   <= 1'b0;
      rx_message_end_irq <= 1'b0;
    end else begin
      rx_pool_full_irq   <= blk_ready && !rx_ann_q && !confirm && !blk_end && !dma_mode; // RULE_07
      rx_message_end_irq <= blk_ready && !rx_ann_q && !confirm && blk_end;               // RULE_09
      if (confirm) rx_ann_q <= 1'b0;
      else if (blk_ready) rx_ann_q <= 1'b1;
    end
  end

  // read position; interrupt mode wraps so the block can be reread
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_cnt_q   <= 6'h00;
      rx_pause_q <= 1'b0;
      rx_done_q  <= 1'b0;
    end else if (confirm) begin
      rx_cnt_q   <= 6'h00;
      rx_pause_q <= 1'b0;
      rx_done_q  <= 1'b0;                                          // RULE_03
    end else begin
      if (rd_rise) rx_cnt_q <= (!dma_mode && rx_cnt_q == blk_len - 6'h01) ? 6'h00
                                                                    : rx_cnt_q + 6'h01; // RULE_08
      if (dma_mode && dma_size == `HCF_BLK_32 && rd_rise && rx_cnt_q == dma_size - 6'h02)
        rx_pause_q <= 1'b1;                                        // RULE_01
      else if (ack_rise && rx_pause_q)
        rx_pause_q <= 1'b0;                                        // RULE_01 RULE_05
      if (dma_size != `HCF_BLK_32 && rd_fall && rx_cnt_q == dma_size - 6'h01)
        rx_done_q <= 1'b1;                                         // RULE_02
      else if (dma_size == `HCF_BLK_32 && ack_fall && rx_cnt_q == dma_size - 6'h01)
        rx_done_q <= 1'b1;                                         // RULE_05
    end
  end

  // ************************************************************
  // bus read path and receive request
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_out       <= 8'h00;
      data_oe_n      <= 1'b1;
      rx_dma_request <= 1'b0;
    end else begin
      data_out       <= rx_mem[rx_base_q + rx_cnt_q];
      data_oe_n      <= !(acc2 && !sy2_q[2]);
      // level held in dma mode while a ready block is not paused, done or confirmed
      rx_dma_request <= dma_mode && blk_ready && !rx_pause_q && !rx_done_q && !confirm; // RULE_04 RULE_26
    end
  end

  // ************************************************************
  // transmit fifo
  // ************************************************************
  logic [7:0]  tx_mem [0:63];                         // RULE_06
  logic [63:0] tx_end_q;
  logic [5:0]  tx_wr_q, tx_rd_q, tx_left_q;
  logic [6:0]  tx_count_q, tx_avail_q;
  logic [11:0] tx_rem_q;
  logic        tx_busy_q, tx_ann_q, tx_pause_q, tx_done_q;
  logic        tx_push, tx_pop, tx_last_w, blk_load, may_load;
  logic [6:0]  tx_free;
  logic [5:0]  next_blk;
  logic        ob1_v_q, ob1_l_q;
  logic [7:0]  ob1_d_q;
  assign tx_free   = `HCF_FIFO_DEPTH - tx_count_q;
  assign may_load  = continuous_frame_tx || !tx_busy_q;                // RULE_15
  assign tx_push   = wr_rise && tx_count_q < `HCF_FIFO_DEPTH;
  assign tx_last_w = dma_mode && tx_rem_q == 12'h001;
  assign next_blk  = tx_rem_q >= 12'h020 ? `HCF_BLK_32 : tx_rem_q[5:0]; // RULE_16
  assign blk_load  = tx_left_q == 6'h00 && tx_rem_q != 12'h000 &&
                     tx_free >= 7'(next_blk);
  assign tx_pop    = tx_avail_q != 7'h00 && !ob1_v_q;

  always_ff @(posedge ref_clk) begin
    if (tx_push) tx_mem[tx_wr_q] <= pin_data;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_wr_q    <= 6'h00;
      tx_rd_q    <= 6'h00;
      tx_count_q <= 7'h00;
      tx_avail_q <= 7'h00;
      tx_end_q   <= 64'h0;                                         // RULE_27
    end else begin
      if (tx_push) begin
        tx_wr_q           <= tx_wr_q + 6'h01;
        tx_end_q[tx_wr_q] <= tx_last_w;
      end else if (tx_frame_end_cmd) begin
        tx_end_q[tx_wr_q - 6'h01] <= 1'b1;
      end
      if (tx_pop) tx_rd_q <= tx_rd_q + 6'h01;
      tx_count_q <= tx_count_q + 7'(tx_push) - 7'(tx_pop);
      // interrupt mode commits on command, dma mode per byte
      if (!dma_mode && (tx_transmit_cmd || tx_frame_end_cmd))
        tx_avail_q <= tx_count_q - 7'(tx_pop);                    // RULE_14
      else
        tx_avail_q <= tx_avail_q + 7'(tx_push && dma_mode) - 7'(tx_pop);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_ann_q          <= 1'b0;
      tx_pool_ready_irq <= 1'b0;
    end else begin
      tx_pool_ready_irq <= !dma_mode && !tx_ann_q && tx_free >= `HCF_HALF_SIZE && may_load; // RULE_14
      if (tx_transmit_cmd || tx_frame_end_cmd) tx_ann_q <= 1'b0;
      else if (!dma_mode && tx_free >= `HCF_HALF_SIZE && may_load) tx_ann_q <= 1'b1;
    end
  end

  // dma transmit: byte budget split into blocks of at most 32
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_rem_q       <= 12'h000;
      tx_left_q      <= 6'h00;
      tx_pause_q     <= 1'b0;
      tx_done_q      <= 1'b0;
      tx_dma_request <= 1'b0;
    end else begin
      if (tx_dma_start_cmd && tx_rem_q == 12'h000 && may_load)     // RULE_15
        tx_rem_q <= {tx_byte_count_high, tx_byte_count_low};       // RULE_16
      else if (tx_push && tx_left_q != 6'h00)
        tx_rem_q <= tx_rem_q - 12'h001;
      if (blk_load) begin
        tx_left_q  <= next_blk;
        tx_pause_q <= 1'b0;
        tx_done_q  <= 1'b0;
      end else if (tx_push && tx_left_q != 6'h00) begin
        tx_left_q <= tx_left_q - 6'h01;
        if (tx_left_q == 6'h02) tx_pause_q <= 1'b1;                // RULE_25
      end else if (ack_rise && tx_pause_q) begin
        tx_pause_q <= 1'b0;                                        // RULE_25
      end else if (ack_fall && tx_left_q == 6'h01 && !tx_pause_q) begin
        tx_done_q <= 1'b1;                                         // RULE_05
      end
      tx_dma_request <= dma_mode && tx_left_q != 6'h00 && !tx_pause_q && !tx_done_q &&
                        !(tx_push && tx_left_q == 6'h02);          // RULE_25
    end
  end

  // ************************************************************
  // two-entry output buffer towards the line engine
  // ************************************************************
  logic       ob_take;
  assign ob_take = tx_byte_ready && tx_byte_valid;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_byte_valid <= 1'b0;
      tx_byte_data  <= 8'h00;
      tx_byte_last  <= 1'b0;
      ob1_v_q       <= 1'b0;
      ob1_d_q       <= 8'h00;
      ob1_l_q       <= 1'b0;
    end else if (ob_take && ob1_v_q) begin
      {tx_byte_data, tx_byte_last} <= {ob1_d_q, ob1_l_q};
      ob1_v_q                      <= 1'b0;
    end else if (tx_pop && (ob_take || !tx_byte_valid)) begin
      tx_byte_valid                <= 1'b1;
      {tx_byte_data, tx_byte_last} <= {tx_mem[tx_rd_q], tx_end_q[tx_rd_q]};
    end else if (tx_pop) begin
      ob1_v_q            <= 1'b1;
      {ob1_d_q, ob1_l_q} <= {tx_mem[tx_rd_q], tx_end_q[tx_rd_q]};
    end else if (ob_take) begin
      tx_byte_valid <= 1'b0;
    end
  end

  // frame in flight until its last byte leaves the buffer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) tx_busy_q <= 1'b0;
    else if (tx_pop) tx_busy_q <= 1'b1;
    else if (ob_take && tx_byte_last) tx_busy_q <= 1'b0;
  end

endmodule

// ===== logic/hcf_params.svh
// Purpose: constants for the hdlc channel fifo and dma block
// Assumes: included by bare name
// Notes:   offsets none; counts and fixed values only
`ifndef HCF_PARAMS_SVH
`define HCF_PARAMS_SVH
`define HCF_FIFO_DEPTH   7'h40
`define HCF_HALF_SIZE    7'h20
`define HCF_GROUP_ADDR_A 8'hFC
`define HCF_GROUP_ADDR_B 8'hFE
`define HCF_MAX_FRAMES   5'h11
`define HCF_BLK_4        6'h04
`define HCF_BLK_8        6'h08
`define HCF_BLK_16       6'h10
`define HCF_BLK_32       6'h20
`endif

// ===== logic/hcf_pkg.sv
// Purpose: types shared by the hdlc channel fifo and dma block
// Assumes: nothing
// Notes:   modes and address states with written codes
package hcf_pkg;
  typedef enum logic [2:0] {
    hcf_mode_auto     = 3'b000,
    hcf_mode_nonauto  = 3'b001,
    hcf_mode_transp0  = 3'b010,
    hcf_mode_transp1  = 3'b011,
    hcf_mode_ext0     = 3'b100,
    hcf_mode_ext1     = 3'b101
  } hcf_mode_t;
  typedef enum logic [1:0] {
    hcf_a_high = 2'b00,
    hcf_a_low  = 2'b01,
    hcf_a_data = 2'b10,
    hcf_a_skip = 2'b11
  } hcf_addr_st_t;
endpackage
